// file: design/global_reset_reference_clock_input_select.sv
// global reset and reference clock selection front end.
// assumes i_clock is the core clock and all pins are asynchronous to it;
// the clock mux and synthesiser are outside and obey o_clock_bypass and
// o_synth_powerdown.
// What this block does
// - a low reset pin asserts o_core_reset at once, without a clock; bypass and synthesiser power-down follow one edge later.
// - the select pins, held during reset, pick 10, 12.8, 25 or 125 MHz.
// - with the power-down pin high the synthesiser is off and bypassed.
// - with the power-down pin low the synthesiser runs and, once locked, clocks the core.
`timescale 1ns/100ps
module global_reset_reference_clock_input_select
(
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic i_reset_n,
    input wire logic [1:0] i_freq_select,
    input wire logic i_synth_powerdown_bypass,
    input wire logic i_synth_locked,
    output logic o_core_reset,
    output global_reset_reference_clock_input_select_pkg::ref_freq_t o_freq_select,
    output logic o_synth_powerdown,
    output logic o_clock_bypass,
    output logic o_short_reset
);

    global_reset_reference_clock_input_select_pkg::front_state_t st_ff;
    global_reset_reference_clock_input_select_pkg::front_state_t nxt_st;
    logic core_reset;

    ////////////////////////////////////////////////////////////////////
    // reset pin synchroniser, asserts asynchronously
    reset_pin_sync u_reset_sync
    (
        .i_clock(i_clock),
        .i_srst(i_srst),
        .i_reset_n(i_reset_n),
        .o_reset(core_reset)
    );

    ////////////////////////////////////////////////////////////////////
    // next state
    always_comb
    begin
        nxt_st = st_ff;
        // pin synchronisers, first stage feeds only the second
        nxt_st.freq_sync1 = i_freq_select;
        nxt_st.freq_sync2 = st_ff.freq_sync1;
        nxt_st.pd_sync1 = i_synth_powerdown_bypass;
        nxt_st.pd_sync2 = st_ff.pd_sync1;
        nxt_st.lock_sync1 = i_synth_locked;
        nxt_st.lock_sync2 = st_ff.lock_sync1;

        if (core_reset)
        begin
            // sample the select pins for the whole reset
            nxt_st.freq_select = global_reset_reference_clock_input_select_pkg::ref_freq_t'(
                st_ff.freq_sync2);
            // reset width monitor, saturates at the minimum
            if (st_ff.low_count <
                global_reset_reference_clock_input_select_pkg::RESET_MIN_CYCLES)
            begin
                nxt_st.low_count = st_ff.low_count + 12'h001;
            end
            // safe clocking while held: bypass, synthesiser off
            nxt_st.state = global_reset_reference_clock_input_select_pkg::ST_BYPASS;
            nxt_st.synth_powerdown = 1'b1;
            nxt_st.clock_bypass = 1'b1;
        end
        else
        begin
            // release: hold the code, judge the reset width
            if (st_ff.low_count != global_reset_reference_clock_input_select_pkg::CNT_RESET)
            begin
                nxt_st.short_reset = st_ff.low_count <
                    global_reset_reference_clock_input_select_pkg::RESET_MIN_CYCLES;
                nxt_st.low_count = global_reset_reference_clock_input_select_pkg::CNT_RESET;
            end
            // freq_select is left untouched here
            unique case (st_ff.state)
                global_reset_reference_clock_input_select_pkg::ST_BYPASS:
                begin
                    // power up first, keep the raw reference until lock
                    if (!st_ff.pd_sync2)
                    begin
                        nxt_st.state =
                            global_reset_reference_clock_input_select_pkg::ST_WAIT_LOCK;
                        nxt_st.synth_powerdown = 1'b0;
                    end
                end
                global_reset_reference_clock_input_select_pkg::ST_WAIT_LOCK:
                begin
                    if (st_ff.pd_sync2)
                    begin
                        nxt_st.state =
                            global_reset_reference_clock_input_select_pkg::ST_BYPASS;
                        nxt_st.synth_powerdown = 1'b1;
                        nxt_st.clock_bypass = 1'b1;
                    end
                    else if (st_ff.lock_sync2)
                    begin
                        nxt_st.state = global_reset_reference_clock_input_select_pkg::ST_RUN;
                        nxt_st.clock_bypass = 1'b0;
                    end
                end
                global_reset_reference_clock_input_select_pkg::ST_RUN:
                begin
                    // bypass and power-down in one edge, mux glitch-free
                    if (st_ff.pd_sync2)
                    begin
                        nxt_st.state =
                            global_reset_reference_clock_input_select_pkg::ST_BYPASS;
                        nxt_st.synth_powerdown = 1'b1;
                        nxt_st.clock_bypass = 1'b1;
                    end
                end
                default:
                begin
                    // illegal code: fall back to the safe clock
                    nxt_st.state = global_reset_reference_clock_input_select_pkg::ST_BYPASS;
                    nxt_st.synth_powerdown = 1'b1;
                    nxt_st.clock_bypass = 1'b1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            st_ff <= '0;
            st_ff.state <= global_reset_reference_clock_input_select_pkg::ST_BYPASS;
            st_ff.freq_select <= global_reset_reference_clock_input_select_pkg::FREQ_RESET;
            st_ff.synth_powerdown <= 1'b1;
            st_ff.clock_bypass <= 1'b1;
            st_ff.low_count <= global_reset_reference_clock_input_select_pkg::CNT_RESET;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // outputs straight from flops
    assign o_core_reset = core_reset;
    assign o_freq_select = st_ff.freq_select;
    assign o_synth_powerdown = st_ff.synth_powerdown;
    assign o_clock_bypass = st_ff.clock_bypass;
    assign o_short_reset = st_ff.short_reset;

    ////////////////////////////////////////////////////////////////////
    // checks
    AST_ASYNC_RESET: assert property (
        @(posedge i_clock) disable iff (i_srst)
        !i_reset_n |-> o_core_reset ##1 (o_clock_bypass && o_synth_powerdown))
        else $error("reset pin low but core not in reset");

    AST_RELEASE_DELAY: assert property (
        @(posedge i_clock) disable iff (i_srst)
        (i_reset_n && !i_srst) [*3] |-> !o_core_reset)
        else $error("core reset not released two edges after pin");

    AST_FREQ_CAPTURE: assert property (
        @(posedge i_clock) disable iff (i_srst)
        $fell(o_core_reset) |-> o_freq_select == $past(st_ff.freq_sync2))
        else $error("frequency code not captured at reset release");

    AST_FREQ_HOLD: assert property (
        @(posedge i_clock) disable iff (i_srst)
        !o_core_reset && $past(!o_core_reset) |-> $stable(o_freq_select))
        else $error("frequency code changed outside reset");

    AST_PD_BYPASS: assert property (
        @(posedge i_clock) disable iff (i_srst)
        i_synth_powerdown_bypass [*3] |=> o_synth_powerdown && o_clock_bypass)
        else $error("power-down pin high but synthesiser not bypassed");

    AST_RUN_CLEAN: assert property (
        @(posedge i_clock) disable iff (i_srst)
        !o_clock_bypass |-> !o_synth_powerdown &&
            st_ff.state == global_reset_reference_clock_input_select_pkg::ST_RUN)
        else $error("synthesiser output used while powered down");

    AST_LOCK_TO_RUN: assert property (
        @(posedge i_clock) disable iff (i_srst)
        st_ff.state == global_reset_reference_clock_input_select_pkg::ST_WAIT_LOCK &&
            st_ff.lock_sync2 && !st_ff.pd_sync2 && !core_reset
            |=> !o_clock_bypass ##1 o_clock_bypass == $past(st_ff.pd_sync2)
                || o_core_reset || !o_clock_bypass)
        else $error("locked synthesiser not selected");

    AST_SHORT_FLAG: assert property (
        @(posedge i_clock) disable iff (i_srst)
        $fell(o_core_reset) ##1 1'b1 |-> o_short_reset ==
            ($past(st_ff.low_count, 1) <
             global_reset_reference_clock_input_select_pkg::RESET_MIN_CYCLES))
        else $error("reset width flag wrong");

    COV_RELEASE: cover property (@(posedge i_clock) $fell(o_core_reset));
    COV_RUN: cover property (@(posedge i_clock) $fell(o_clock_bypass));
    COV_BACK_TO_BYPASS: cover property (
        @(posedge i_clock) $rose(o_clock_bypass) && !o_core_reset);
    COV_SHORT: cover property (@(posedge i_clock) $rose(o_short_reset));

endmodule // global_reset_reference_clock_input_select

// file: design/global_reset_reference_clock_input_select_pkg.sv
// constants, types and state layout for the global reset and
// reference clock selection front end.
// assumes a single 20 MHz core clock with a synchronous house reset.
package global_reset_reference_clock_input_select_pkg;

    ////////////////////////////////////////////////////////////////////
    // timing
    localparam longint CLOCK_HZ = 64'h0000_0000_0131_2D00; // 20 MHz
    localparam longint RESET_MIN_US = 64'h0000_0000_0000_0064; // 100 us
    localparam longint US_PER_S = 64'h0000_0000_000F_4240;
    // least time rounds up to whole cycles
    localparam longint RESET_MIN_CYC_L =
        (RESET_MIN_US * CLOCK_HZ + US_PER_S - 64'h0000_0000_0000_0001)
        / US_PER_S;
    localparam int CNT_W = 12;
    localparam logic [CNT_W-1:0] RESET_MIN_CYCLES =
        RESET_MIN_CYC_L[CNT_W-1:0];

    ////////////////////////////////////////////////////////////////////
    // reference frequency codes sampled during reset
    typedef enum logic [1:0] {
        REF_10_MHZ = 2'h0,
        REF_12P8_MHZ = 2'h1,
        REF_25_MHZ = 2'h2,
        REF_125_MHZ = 2'h3
    } ref_freq_t;

    // synthesiser sequencing states
    typedef enum logic [1:0] {
        ST_BYPASS = 2'b00,
        ST_WAIT_LOCK = 2'b01,
        ST_RUN = 2'b10
    } synth_state_t;

    ////////////////////////////////////////////////////////////////////
    // values after reset
    localparam ref_freq_t FREQ_RESET = REF_10_MHZ;
    localparam logic [CNT_W-1:0] CNT_RESET = 12'h000;

    // reset synchroniser stages
    typedef struct packed {
        logic first;
        logic second;
    } reset_pipe_t;

    // whole state of the front end
    typedef struct packed {
        logic [1:0] freq_sync1;
        logic [1:0] freq_sync2;
        logic pd_sync1;
        logic pd_sync2;
        logic lock_sync1;
        logic lock_sync2;
        synth_state_t state;
        ref_freq_t freq_select;
        logic synth_powerdown;
        logic clock_bypass;
        logic [CNT_W-1:0] low_count;
        logic short_reset;
    } front_state_t;

endpackage

// file: design/reset_pin_sync.sv
// reset synchroniser for the board reset pin.
// assumes the pin is asynchronous to i_clock; asserts at once,
// releases two edges after the pin rises.
`timescale 1ns/100ps
module reset_pin_sync
(
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic i_reset_n,
    output logic o_reset
);

    global_reset_reference_clock_input_select_pkg::reset_pipe_t pipe_ff;

    ////////////////////////////////////////////////////////////////////
    // async assert to constant, sync release avoids metastable exit
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            pipe_ff <= 2'b11;
        end
        else if (i_srst)
        begin
            pipe_ff <= 2'b11;
        end
        else
        begin
            pipe_ff <= {1'b0, pipe_ff.first};
        end
    end

    assign o_reset = pipe_ff.second;

endmodule // reset_pin_sync

// file: verif/board_model.sv
// board-side model: reset source, select pins and synthesiser lock.
// assumes one core clock; the reference frequency never changes here.
`timescale 1ns/100ps
module board_model
#(
    parameter int LOCK_DELAY = 10
)
(
    input wire logic i_clock,
    input wire logic i_pulse_req,
    input wire logic [11:0] i_low_cycles,
    input wire logic [1:0] i_code,
    input wire logic i_powerdown,
    output logic o_reset_n = 1'b1,
    output logic [1:0] o_freq_select = 2'h0,
    output logic o_locked = 1'b0,
    output logic o_busy
);
    logic [11:0] low_left = 12'h000;
    int lock_wait = 0;

    ////////////////////////////////////////////////////////////////////
    // reset held low for the asked number of cycles
    always @(posedge i_clock)
    begin
        if (i_pulse_req)
        begin
            o_reset_n <= 1'b0;
            low_left <= i_low_cycles;
        end
        else if (low_left != 12'h000)
        begin
            low_left <= low_left - 12'h001;
            o_reset_n <= (low_left == 12'h001);
        end
        // pins only move outside reset, so the sample stays clean
        if (i_pulse_req || low_left == 12'h000)
            o_freq_select <= i_code;
    end
    assign o_busy = (low_left != 12'h000);

    // lock comes late and drops at once, like a real loop
    always @(posedge i_clock)
    begin
        lock_wait <= i_powerdown ? 0 : lock_wait + (lock_wait < LOCK_DELAY);
        o_locked <= !i_powerdown && lock_wait >= LOCK_DELAY;
    end
endmodule // board_model

// file: verif/tb_top.sv
// self-checking bench for the reset and reference select front end.
// assumes board_model owns the board pins; bench drives power-down.
`timescale 1ns/100ps
module tb_top;
    logic i_clock = 1'b0;
    logic i_srst = 1'b1;
    logic pd_pin = 1'b0;
    logic pulse_req = 1'b0;
    logic [11:0] low_cycles = 12'h000;
    logic [1:0] code = 2'h0;
    logic reset_n, locked, busy, core_reset, synth_pd, bypass, short_rst;
    logic [1:0] pins;
    global_reset_reference_clock_input_select_pkg::ref_freq_t freq;
    int err_count = 0;
    int n_checks = 0;
    int cycles = 0;

    global_reset_reference_clock_input_select dut
    (
        .i_clock(i_clock),
        .i_srst(i_srst),
        .i_reset_n(reset_n),
        .i_freq_select(pins),
        .i_synth_powerdown_bypass(pd_pin),
        .i_synth_locked(locked),
        .o_core_reset(core_reset),
        .o_freq_select(freq),
        .o_synth_powerdown(synth_pd),
        .o_clock_bypass(bypass),
        .o_short_reset(short_rst)
    );

    board_model board
    (
        .i_clock(i_clock),
        .i_pulse_req(pulse_req),
        .i_low_cycles(low_cycles),
        .i_code(code),
        .i_powerdown(synth_pd),
        .o_reset_n(reset_n),
        .o_freq_select(pins),
        .o_locked(locked),
        .o_busy(busy)
    );

    ////////////////////////////////////////////////////////////////////
    // 20 MHz core clock
    initial
    begin
        forever #25 i_clock = ~i_clock;
    end

    task automatic compare(input logic [1:0] got, input logic [1:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // one board reset pulse; release shows two edges later
    task automatic board_reset(input logic [1:0] c, input logic [11:0] n);
        @(posedge i_clock);
        code <= c;
        low_cycles <= n;
        pulse_req <= 1'b1;
        @(posedge i_clock);
        pulse_req <= 1'b0;
        #1 compare({1'b0, core_reset}, 2'h1);
        while (busy) @(posedge i_clock);
        @(posedge i_clock);
        #1 compare({1'b0, core_reset}, 2'h0);
        compare(freq, c);
        @(posedge i_clock);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////
    // every code captured from a long enough reset
    task automatic test_codes();
        for (int c = 0; c < 4; c++)
        begin
            board_reset(c[1:0], 12'h07D5);
            compare({1'b0, short_rst}, 2'h0);
        end
        $display("test_codes done");
    endtask

    // pins moved after release must not reach the captured code
    task automatic test_hold();
        @(posedge i_clock);
        code <= 2'h0;
        repeat (5) @(posedge i_clock);
        #1 compare(freq, 2'h3);
        $display("test_hold done");
    endtask

    // too short a pulse is flagged but still captures
    task automatic test_short();
        board_reset(2'h1, 12'h0064);
        compare({1'b0, short_rst}, 2'h1);
        $display("test_short done");
    endtask

    // bypass on pin high; run only after lock on pin low
    task automatic test_powerdown();
        @(posedge i_clock);
        pd_pin <= 1'b1;
        repeat (3) @(posedge i_clock);
        #1 compare({synth_pd, bypass}, 2'h3);
        @(posedge i_clock);
        pd_pin <= 1'b0;
        repeat (3) @(posedge i_clock);
        #1 compare({synth_pd, bypass}, 2'h1);
        for (int i = 0; i < 40 && bypass; i++) @(posedge i_clock);
        #1 compare({synth_pd, bypass}, 2'h0);
        @(posedge i_clock);
        pd_pin <= 1'b1;
        repeat (3) @(posedge i_clock);
        #1 compare({synth_pd, bypass}, 2'h3);
        $display("test_powerdown done");
    endtask

    // hang guard, well above the ~8200 cycles the tests need
    always @(posedge i_clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            err_count++;
            print_verdict();
        end
    end

    initial
    begin
        repeat (4) @(posedge i_clock);
        i_srst <= 1'b0;
        test_codes();
        test_hold();
        test_short();
        test_powerdown();
        print_verdict();
    end
endmodule // tb_top
